// ---- verilog/tap_controller.sv ----
// Test access port controller with instruction, bypass, id and user data registers.
// Assumes test pins arrive asynchronously and TCK is much slower than clk_sys.
//
// Summary of operation
// - Sixteen states stepped by TMS at TCK rise
// - Power-on reset enters Test-Logic-Reset
// - All shifting is least significant bit first
// - Shift-IR takes four instruction bits from TDI
// - Last instruction bit enters on exit edge
// - Captured instruction value 0x01 goes out TDO
// - Instruction selects data register and its logic
// - Instruction output updates in Update-IR
// - IR exit and pause states do nothing
// - TMS 1,0,0 reaches Shift-DR, shifting TDI
// - Last data bit enters on exit edge
// - Capture-DR loads, then shifts out captured value
// - Latched data output updates only in Update-DR
// - DR exit and pause states do nothing
// - Update may pass to Select-DR; idle visible
// - Five TMS-high periods reach Test-Logic-Reset
// - No test reset pin; other resets only
// - Unprogrammed fuse: pins are port, controller reset
// - Fuse programmed, disable clear: pullups, port on
`timescale 1ns/1ps
module tap_controller #(
	parameter int DR_W = 8,
	parameter logic [31:0] ID_VALUE = 32'h1234_5671 // Arbitrary identity value
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Test pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	// Port gating
	input wire logic port_enable_fuse,
	input wire logic port_disable_bit,
	output logic tap_pins_active,
	output logic pin_pullup_en,
	// Controller view for the rest of the chip
	output logic [tap_pkg::IR_W-1:0] instr,
	output logic in_run_idle,
	// User data register parallel ports
	input wire logic [DR_W-1:0] user_dr_in,
	output logic [DR_W-1:0] user_dr_out
);

	if (DR_W < 1 || DR_W > tap_pkg::CHAIN_W) begin : g_bad_width
		$error("DR_W must lie between 1 and the chain width");
	end

	logic [2:0] pins_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_prev_q;
	logic tck_prev_d;
	logic tck_rise;
	logic tck_fall;
	logic port_en;
	tap_pkg::tap_state_t state_q;
	tap_pkg::tap_state_t state_d;
	logic [tap_pkg::IR_W-1:0] ir_shift_q;
	logic [tap_pkg::IR_W-1:0] ir_shift_d;
	logic [tap_pkg::IR_W-1:0] ir_q;
	logic [tap_pkg::IR_W-1:0] ir_d;
	logic [tap_pkg::CHAIN_W-1:0] dr_shift_q;
	logic [tap_pkg::CHAIN_W-1:0] dr_shift_d;
	logic [DR_W-1:0] user_q;
	logic [DR_W-1:0] user_d;
	logic tdo_q;
	logic tdo_d;
	logic shifting;
	int sel_len;
	logic [2:0] hi_cnt_q; // Consecutive TMS-high rises, for the reset check
	logic [2:0] hi_cnt_d;

	// Pin synchronisation, test clock sampled like any pin
	tap_sync #(
		.W(3)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({tck, tms, tdi}),
		.sync_out(pins_s)
	);

	assign tck_s = pins_s[2];
	assign tms_s = pins_s[1];
	assign tdi_s = pins_s[0];
	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;

	assign port_en = port_enable_fuse & ~port_disable_bit;
	assign tap_pins_active = port_en;
	assign pin_pullup_en = port_en;

	always_comb begin
		if (ir_q == tap_pkg::INS_IDCODE) begin
			sel_len = tap_pkg::ID_W;
		end else if (ir_q == tap_pkg::INS_USER) begin
			sel_len = DR_W;
		end else begin
			sel_len = tap_pkg::BYPASS_W;
		end
	end

	// Shift right, new bit enters at the top of the active length
	function automatic logic [tap_pkg::CHAIN_W-1:0] shift_in(
		input logic [tap_pkg::CHAIN_W-1:0] v,
		input int len,
		input logic b
	);
		logic [tap_pkg::CHAIN_W-1:0] r;
		r = v >> 1;
		r[len-1] = b;
		return r;
	endfunction : shift_in

	// Next state and register values
	always_comb begin
		state_d = state_q;
		ir_shift_d = ir_shift_q;
		ir_d = ir_q;
		dr_shift_d = dr_shift_q;
		user_d = user_q;
		tck_prev_d = tck_s;
		hi_cnt_d = hi_cnt_q;
		if (!port_en) begin
			state_d = tap_pkg::ST_RESET;
			ir_d = tap_pkg::IR_RESET;
		end else if (tck_rise) begin
			// Count TMS-high rises, saturating
			hi_cnt_d = !tms_s ? 3'h0 : (hi_cnt_q == 3'h7 ? hi_cnt_q : hi_cnt_q + 3'h1);
			case (state_q)
				tap_pkg::ST_RESET: begin
					state_d = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
				end
				tap_pkg::ST_IDLE: begin
					state_d = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
				end
				tap_pkg::ST_SEL_DR: begin
					state_d = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
				end
				tap_pkg::ST_CAP_DR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
				end
				tap_pkg::ST_SHIFT_DR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
				end
				tap_pkg::ST_EXIT1_DR: begin
					state_d = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
				end
				tap_pkg::ST_PAUSE_DR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
				end
				tap_pkg::ST_EXIT2_DR: begin
					state_d = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
				end
				tap_pkg::ST_SEL_IR: begin
					state_d = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
				end
				tap_pkg::ST_CAP_IR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
				end
				tap_pkg::ST_SHIFT_IR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
				end
				tap_pkg::ST_EXIT1_IR: begin
					state_d = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
				end
				tap_pkg::ST_PAUSE_IR: begin
					state_d = tms_s ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
				end
				tap_pkg::ST_EXIT2_IR: begin
					state_d = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
				end
				default: begin
					// both update states may go to Select-DR
					state_d = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
				end
			endcase
			// Register actions of the state being left
			case (state_q)
				tap_pkg::ST_RESET: begin
					ir_d = tap_pkg::IR_RESET;
				end
				tap_pkg::ST_CAP_IR: begin
					ir_shift_d = tap_pkg::IR_CAPTURE;
				end
				tap_pkg::ST_SHIFT_IR: begin
					ir_shift_d = {tdi_s, ir_shift_q[tap_pkg::IR_W-1:1]};
				end
				tap_pkg::ST_UPD_IR: begin
					ir_d = ir_shift_q;
				end
				tap_pkg::ST_CAP_DR: begin
					if (ir_q == tap_pkg::INS_IDCODE) begin
						dr_shift_d = ID_VALUE;
					end else if (ir_q == tap_pkg::INS_USER) begin
						dr_shift_d = '0;
						dr_shift_d[DR_W-1:0] = user_dr_in;
					end else begin
						dr_shift_d = '0;
					end
				end
				tap_pkg::ST_SHIFT_DR: begin
					dr_shift_d = shift_in(dr_shift_q, sel_len, tdi_s);
				end
				tap_pkg::ST_UPD_DR: begin
					if (ir_q == tap_pkg::INS_USER) begin
						user_d = dr_shift_q[DR_W-1:0];
					end
				end
				default: begin
					ir_d = ir_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= tap_pkg::ST_RESET;
			ir_shift_q <= '0;
			ir_q <= tap_pkg::IR_RESET;
			dr_shift_q <= '0;
			user_q <= '0;
			tck_prev_q <= 1'b0;
			hi_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			ir_shift_q <= ir_shift_d;
			ir_q <= ir_d;
			dr_shift_q <= dr_shift_d;
			user_q <= user_d;
			tck_prev_q <= tck_prev_d;
			hi_cnt_q <= hi_cnt_d;
		end
	end

	always_comb begin
		tdo_d = tdo_q;
		if (tck_fall) begin
			if (state_q == tap_pkg::ST_SHIFT_IR) begin
				tdo_d = ir_shift_q[0];
			end else begin
				tdo_d = dr_shift_q[0];
			end
		end
	end

	// TDO data register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tdo_q <= 1'b0;
		end else begin
			tdo_q <= tdo_d;
		end
	end

	assign shifting = (state_q == tap_pkg::ST_SHIFT_IR) || (state_q == tap_pkg::ST_SHIFT_DR);
	assign tdo_oe_n = ~shifting;
	assign tdo = tdo_q;
	assign instr = ir_q;
	assign in_run_idle = (state_q == tap_pkg::ST_IDLE);
	assign user_dr_out = user_q;

	sequence s_rise_in(tap_pkg::tap_state_t st);
		tck_rise && port_en && state_q == st;
	endsequence

	AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (reset)
		$onehot(state_q)) else $error("state is not one-hot");

	AST_FIVE_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
		hi_cnt_q >= 3'(tap_pkg::TMS_RESET_EDGES) |-> state_q == tap_pkg::ST_RESET)
		else $error("five TMS highs did not reset");

	AST_DISABLED: assert property (@(posedge clk_sys) disable iff (reset)
		!port_en |=> state_q == tap_pkg::ST_RESET && tdo_oe_n) else $error("disabled port not in reset");

	AST_CAP_IR: assert property (@(posedge clk_sys) disable iff (reset)
		s_rise_in(tap_pkg::ST_CAP_IR) |=> ir_shift_q == tap_pkg::IR_CAPTURE) else $error("IR capture wrong");

	AST_IR_SHIFT: assert property (@(posedge clk_sys) disable iff (reset)
		s_rise_in(tap_pkg::ST_SHIFT_IR) |=> ir_shift_q == {$past(tdi_s), $past(ir_shift_q[3:1])})
		else $error("IR shift not LSB first");

	AST_IR_UPDATE: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(ir_q) |-> $past(state_q) inside {tap_pkg::ST_UPD_IR, tap_pkg::ST_RESET} || !$past(port_en))
		else $error("instruction changed outside update");

	AST_DR_UPDATE: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(user_q) |-> $past(state_q) == tap_pkg::ST_UPD_DR && $past(tck_rise))
		else $error("user output changed outside update");

	AST_USER_CAP: assert property (@(posedge clk_sys) disable iff (reset)
		(s_rise_in(tap_pkg::ST_CAP_DR) ##0 ir_q == tap_pkg::INS_USER)
		|=> dr_shift_q[DR_W-1:0] == $past(user_dr_in)) else $error("user capture wrong");

	AST_TDO_FALL: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(tdo_q) |-> $past(tck_fall)) else $error("TDO changed off falling edge");

	AST_TDO_OE: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(tdo_oe_n) |-> $past(state_q) inside {tap_pkg::ST_CAP_IR, tap_pkg::ST_EXIT2_IR, tap_pkg::ST_CAP_DR,
		tap_pkg::ST_EXIT2_DR}) else $error("TDO drive began outside a shift entry");

endmodule : tap_controller

// ---- verilog/tap_pkg.sv ----
// Shared constants and types of the test access port controller.
// Assumes a single system clock that oversamples the test clock pin.
package tap_pkg;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET    = 16'h0001,
		ST_IDLE     = 16'h0002,
		ST_SEL_DR   = 16'h0004,
		ST_CAP_DR   = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR   = 16'h0100,
		ST_SEL_IR   = 16'h0200,
		ST_CAP_IR   = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR   = 16'h8000
	} tap_state_t;

	// Instruction register layout
	localparam int IR_W = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] INS_IDCODE = 4'h1;
	localparam logic [3:0] INS_USER = 4'h2;
	localparam logic [3:0] INS_BYPASS = 4'hf;
	localparam logic [3:0] IR_RESET = INS_IDCODE;

	// Data register lengths
	localparam int ID_W = 32;
	localparam int BYPASS_W = 1;
	localparam int CHAIN_W = 32;

	// Consecutive high TMS edges that always reach the reset state
	localparam int TMS_RESET_EDGES = 5;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

endpackage : tap_pkg

// ---- verilog/tap_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are levels slow against the system clock.
`timescale 1ns/1ps
module tap_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	if (W < 1) begin : g_bad_width
		$error("W must be at least one");
	end

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Register both stages
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : tap_sync

// ---- tb/probe_model.sv ----
// Tester model that drives the test pins and records what comes back.
// Assumes clk_sys runs eight times faster than the test clock.
`timescale 1ns/1ps
module probe_model (
	// Clock
	input wire logic clk_sys,
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	// Frame results
	output logic done,
	output logic [63:0] seen,
	output logic [63:0] seen_oe_n
);
	// Pins rest at their pulled-up levels, clock still
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		done = 1'b0;
		seen = 64'h0;
		seen_oe_n = 64'h0;
	end

	// Clocks one frame of n bits, low phase first, 4 clk_sys per phase
	// bit 0 first
	task automatic scan(input logic [63:0] tms_v, input logic [63:0] tdi_v, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			tck <= 1'b0;
			tms <= tms_v[i];
			tdi <= tdi_v[i];
			repeat (4) @(posedge clk_sys);
			tck <= 1'b1;
			repeat (2) @(posedge clk_sys);
			seen[i] <= tdo_oe_n ? 1'b1 : tdo; // Released line reads high
			seen_oe_n[i] <= tdo_oe_n;
			@(posedge clk_sys);
		end
		@(posedge clk_sys);
		tck <= 1'b0;
		tms <= 1'b1;
		tdi <= 1'b1;
		done <= 1'b1;
		@(posedge clk_sys);
		done <= 1'b0;
	endtask : scan
endmodule : probe_model

// ---- tb/tap_controller_tb.sv ----
// Self-checking bench of the test access port controller.
// Assumes the probe model owns the test pins.
`timescale 1ns/1ps
module tap_controller_tb;
	localparam int DRW = 8;
	localparam logic [31:0] ID_V = 32'h0bad_c0de; // Arbitrary identity value
	typedef struct packed {logic [63:0] val; logic [63:0] msk; int n;} note_t;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic tck, tms, tdi, tdo, tdo_oe_n, done, tap_pins_active, pin_pullup_en, in_run_idle;
	logic port_enable_fuse, port_disable_bit;
	logic [3:0] instr;
	logic [DRW-1:0] user_dr_in, user_dr_out;
	logic [63:0] seen, seen_oe_n, lm;
	logic [31:0] v, w;
	note_t exp_q[$];
	note_t nt;
	int seed, n_errors = 0, cmp_count = 0;

	// Clock
	always #20 clk_sys = ~clk_sys;

	tap_controller #(.DR_W(DRW), .ID_VALUE(ID_V)) dut_u (.clk_sys(clk_sys), .reset(reset), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .port_enable_fuse(port_enable_fuse),
		.port_disable_bit(port_disable_bit), .tap_pins_active(tap_pins_active),
		.pin_pullup_en(pin_pullup_en), .instr(instr), .in_run_idle(in_run_idle),
		.user_dr_in(user_dr_in), .user_dr_out(user_dr_out));

	probe_model probe_u (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n), .done(done), .seen(seen), .seen_oe_n(seen_oe_n));

	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s: expected %h, seen %h", what, e, s);
		end
	endtask : chk

	// Compares each finished frame with the oldest note
	always @(posedge clk_sys) begin
		if (done) begin
			nt = exp_q.pop_front();
			lm = (64'h1 << nt.n) - 64'h1;
			// Released bits read as the pull-up level
			chk("tdo", (nt.val & nt.msk) | (~nt.msk & lm), seen & lm);
			chk("tdo_oe_n", ~nt.msk & lm, seen_oe_n & lm);
		end
	end

	task automatic frame(input logic [63:0] t, input logic [63:0] d, input int n, input logic [63:0] e,
		input logic [63:0] m);
		exp_q.push_back(note_t'{e, m, n});
		probe_u.scan(t, d, n);
		@(posedge clk_sys);
	endtask : frame

	task automatic ir_scan(input logic [3:0] code, input logic sel);
		frame({54'h0, sel, 9'h183}, {56'h0, code, 4'h0}, 10, 64'h10, 64'hf0);
		chk("instr", 64'(code), 64'(instr));
		chk("idle", 64'(!sel), 64'(in_run_idle));
	endtask : ir_scan

	task automatic dr_scan(input logic [31:0] d, input int n, input logic sel, input logic [31:0] e);
		int p;
		p = sel ? 2 : 3;
		frame((sel ? 64'h0 : 64'h1) | (64'h3 << (p + n - 1)), {32'h0, d} << p, p + n + 2,
			{32'h0, e} << p, ((64'h1 << n) - 64'h1) << p);
	endtask : dr_scan

	task automatic conclude;
		$display("Comparisons %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// Watchdog
	initial begin
		#2000000;
		n_errors++;
		conclude();
	end

	// Main sequence
	initial begin
		seed = 31;
		port_enable_fuse = 1'b1;
		port_disable_bit = 1'b0;
		user_dr_in = '0;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("instr", 64'h1, 64'(instr));
		frame(64'h0, 64'h0, 1, 64'h0, 64'h0);
		chk("idle", 64'h1, 64'(in_run_idle));
		w = $random(seed);
		ir_scan(4'h1, 1'b0);
		dr_scan(w, 32, 1'b0, ID_V);
		ir_scan(4'hf, 1'b1);
		dr_scan(32'h3, 2, 1'b1, 32'h2);
		// User register with random capture and update values
		for (int k = 0; k < 3; k++) begin
			ir_scan(4'h2, k[0]);
			v = $random(seed);
			w = $random(seed);
			user_dr_in <= v[DRW-1:0];
			dr_scan(w, DRW, k[0], v);
			chk("user_dr_out", 64'(w[DRW-1:0]), 64'(user_dr_out));
		end
		ir_scan(4'hf, 1'b0);
		dr_scan(32'h0, 1, 1'b0, 32'h0);
		chk("user_dr_out", 64'(w[DRW-1:0]), 64'(user_dr_out));
		ir_scan(4'h2, 1'b0);
		frame(64'hf9, 64'h0, 9, {63'h0, v[0]} << 3, 64'h8);
		chk("instr", 64'h1, 64'(instr));
		chk("idle", 64'h1, 64'(in_run_idle));
		// Both disabled settings of the port
		for (int k = 0; k < 2; k++) begin
			port_enable_fuse <= k[0];
			port_disable_bit <= k[0];
			@(posedge clk_sys);
			@(posedge clk_sys);
			chk("tap_pins_active", 64'h0, 64'(tap_pins_active));
			chk("pin_pullup_en", 64'h0, 64'(pin_pullup_en));
			frame(64'h183, 64'h20, 10, 64'h0, 64'h0);
			chk("instr", 64'h1, 64'(instr));
			port_enable_fuse <= 1'b1;
			port_disable_bit <= 1'b0;
			@(posedge clk_sys);
			@(posedge clk_sys);
			chk("pin_pullup_en", 64'h1, 64'(pin_pullup_en));
			chk("tap_pins_active", 64'h1, 64'(tap_pins_active));
			frame(64'h0, 64'h0, 1, 64'h0, 64'h0);
			ir_scan(4'h2, 1'b0);
		end
		conclude();
	end
endmodule : tap_controller_tb
